// ### hw/tarc_defs.svh
// Timing counts, limits, encodings and reset values of the alarm and relay block.
// Assumes a 40 MHz reference clock; temperatures are in tenths of a kelvin.
`ifndef TARC_DEFS_SVH
`define TARC_DEFS_SVH

`define TARC_CLK_HZ 40000000
`define TARC_DISP_ALT_MS 500

`define TARC_SETPT_MAX 16'h270f
`define TARC_DBAND_MAX 16'h03e7
`define TARC_FLAG_MAX 16'h0001
`define TARC_RELAY_MAX 16'h0002
`define TARC_UNITS_MAX 16'h0003
`define TARC_PICK_MAX 16'h0002

`define TARC_CURVE_NONE 5'h00
`define TARC_CURVE_USER 5'h15
`define TARC_CURVE_SLOTS 9

`define TARC_FMT_VK 2'h0
`define TARC_FMT_OHM 2'h1
`define TARC_FMT_LOG 2'h2
`define TARC_FMT_NONE 2'h3

`define TARC_PICK_INPUT 16'h0000
`define TARC_PICK_ALARM 16'h0001

`define TARC_RST_CURVE 5'h01
`define TARC_RST_UNITS 2'h0
`define TARC_RST_SETPT 14'h0000
`define TARC_RST_DBAND 10'h000
`define TARC_RST_RELAY 2'h0

`endif

// ### hw/tarc_pkg.sv
// Types shared by the alarm and relay block.
// Constants live in tarc_defs.svh.
package tarc_pkg;

	typedef enum logic [1:0] {
		TARC_UNITS_KELVIN = 2'h0,
		TARC_UNITS_CELSIUS = 2'h1,
		TARC_UNITS_FAHRENHEIT = 2'h2,
		TARC_UNITS_SENSOR = 2'h3
	} tarc_units_e;

	typedef enum logic [1:0] {
		TARC_RELAY_OFF = 2'h0,
		TARC_RELAY_ON = 2'h1,
		TARC_RELAY_FOLLOW = 2'h2
	} tarc_relay_e;

	typedef enum logic [3:0] {
		TARC_MENU_NORMAL = 4'h0,
		TARC_MENU_PICK = 4'h1,
		TARC_MENU_CURVE = 4'h2,
		TARC_MENU_UNITS = 4'h3,
		TARC_MENU_ALARM_MENU_ENTRY = 4'h4,
		TARC_MENU_HIGH_SETPOINT = 4'h5,
		TARC_MENU_LOW_SETPOINT = 4'h6,
		TARC_MENU_DEADBAND = 4'h7,
		TARC_MENU_LATCH_SETTING = 4'h8,
		TARC_MENU_RELAY_ONE_SETTING = 4'h9,
		TARC_MENU_RELAY_TWO_SETTING = 4'ha
	} tarc_menu_e;

	typedef enum logic [1:0] {
		TARC_SHOW_READING = 2'h0,
		TARC_SHOW_HIGH_ALARM_MESSAGE = 2'h1,
		TARC_SHOW_LOW_ALARM_MESSAGE = 2'h2,
		TARC_SHOW_MENU = 2'h3
	} tarc_show_e;

	typedef struct packed {
		tarc_show_e show;
		tarc_menu_e item;
		logic [15:0] value;
	} tarc_disp_s;

endpackage : tarc_pkg

// ### hw/tarc_alarm_flag.sv
// One alarm flag with enable, latching and hysteresis release.
// Trip and release conditions come from the same clock domain.
module tarc_alarm_flag (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_enable,
	input wire logic i_trip,
	input wire logic i_release,
	input wire logic i_latch_en,
	input wire logic i_clear,
	output logic o_flag
);

	// Trip wins over a clear in the same cycle
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_flag <= 1'b0;
		end else if (!i_enable) begin
			o_flag <= 1'b0;
		end else if (i_trip) begin
			o_flag <= 1'b1;
		end else if (i_latch_en) begin
			if (i_clear) begin
				o_flag <= 1'b0;
			end
		end else if (i_release) begin
			o_flag <= 1'b0;
		end
	end

	a_flag_latch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_enable && i_latch_en && o_flag && !i_clear |=> o_flag)
		else $error("latched alarm dropped without a clear");

	a_flag_latch_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_enable && i_latch_en && i_clear && !i_trip |=> !o_flag)
		else $error("latched alarm survived a clear");

	a_flag_hyst_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_enable && !i_latch_en && o_flag && !i_release |=> o_flag)
		else $error("alarm released before deadband was crossed");

	a_flag_enable_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!i_enable |=> !o_flag)
		else $error("alarm active while disabled");

endmodule : tarc_alarm_flag

// ### hw/tarc_top.sv
// Temperature alarm, relay and front-panel setting logic.
// Assumes a kelvin reading and curve-range flags from the measurement path on i_ref_clk;
// keys are raw pins and are synchronised here.
`include "tarc_defs.svh"

module tarc_top #(
	parameter int P_ALT_CYCLES = `TARC_DISP_ALT_MS * (`TARC_CLK_HZ / 1000)
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_key_up,
	input wire logic i_key_down,
	input wire logic i_key_select,
	input wire logic i_key_enter,
	input wire logic [2:0] i_input_type,
	input wire logic [1:0] i_user_curve_fmt,
	input wire logic i_user_curve_valid,
	input wire logic [15:0] i_reading_k,
	input wire logic [15:0] i_reading_raw,
	input wire logic i_above_curve,
	input wire logic i_below_curve,
	output logic o_alarm_hi,
	output logic o_alarm_lo,
	output logic o_relay1,
	output logic o_relay2,
	output logic [4:0] o_curve,
	output logic [3:0] o_unit_lamp,
	output tarc_pkg::tarc_disp_s o_disp
);

	logic [3:0] key_meta;
	logic [3:0] key_sync;
	logic [3:0] key_prev;
	logic up_press;
	logic down_press;
	logic sel_press;
	logic ent_press;
	tarc_pkg::tarc_menu_e state_reg;
	tarc_pkg::tarc_menu_e state_next;
	logic [15:0] edit_reg;
	logic [15:0] edit_next;
	logic [15:0] edit_max;
	logic [15:0] load_val;
	logic [15:0] pick_reg;
	logic [4:0] curve_reg;
	tarc_pkg::tarc_units_e units_reg;
	logic alarm_en_reg;
	logic [13:0] hi_reg;
	logic [13:0] lo_reg;
	logic [9:0] db_reg;
	logic latch_reg;
	tarc_pkg::tarc_relay_e r1_reg;
	tarc_pkg::tarc_relay_e r2_reg;
	logic alarm_on;
	logic hi_trip;
	logic lo_trip;
	logic hi_release;
	logic lo_release;
	logic [24:0] alt_cnt_reg;
	logic alt_tick;
	tarc_pkg::tarc_show_e show_next;

	// Format that a curve holds; empty slots give none
	function automatic logic [1:0] curve_fmt(input logic [4:0] id, input logic [1:0] ufmt,
			input logic uvalid);
		logic [1:0] f;
		f = `TARC_FMT_NONE;
		case (id)
			5'h01, 5'h02, 5'h03: f = `TARC_FMT_VK;
			5'h06, 5'h07: f = `TARC_FMT_OHM;
			`TARC_CURVE_USER: f = uvalid ? ufmt : `TARC_FMT_NONE;
			default: f = `TARC_FMT_NONE;
		endcase
		return f;
	endfunction : curve_fmt

	// Format that an input type expects
	function automatic logic [1:0] type_fmt(input logic [2:0] t);
		logic [1:0] f;
		f = `TARC_FMT_NONE;
		case (t)
			3'h0, 3'h1: f = `TARC_FMT_VK;
			3'h2, 3'h3, 3'h4: f = `TARC_FMT_OHM;
			3'h5: f = `TARC_FMT_LOG;
			default: f = `TARC_FMT_NONE;
		endcase
		return f;
	endfunction : type_fmt

	// Next offered curve in the ring 0..7, user; mismatched formats skipped
	function automatic logic [4:0] next_curve(input logic [4:0] cur, input logic up,
			input logic [2:0] itype, input logic [1:0] ufmt, input logic uvalid);
		int idx;
		int cand;
		logic [4:0] id;
		logic [4:0] res;
		logic found;
		idx = (cur == `TARC_CURVE_USER) ? 8 : int'(cur[2:0]);
		res = cur;
		found = 1'b0;
		for (int k = 1; k < `TARC_CURVE_SLOTS; k++) begin
			cand = up ? (idx + k) % `TARC_CURVE_SLOTS
				: (idx + `TARC_CURVE_SLOTS - k) % `TARC_CURVE_SLOTS;
			id = (cand == 8) ? `TARC_CURVE_USER : 5'(cand);
			if (!found && (id == `TARC_CURVE_NONE
					|| (curve_fmt(id, ufmt, uvalid) != `TARC_FMT_NONE
					&& curve_fmt(id, ufmt, uvalid) == type_fmt(itype)))) begin
				res = id;
				found = 1'b1;
			end
		end
		return res;
	endfunction : next_curve

	// Key synchroniser and press detection
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			key_meta <= 4'h0;
			key_sync <= 4'h0;
			key_prev <= 4'h0;
		end else begin
			key_meta <= {i_key_enter, i_key_select, i_key_down, i_key_up};
			key_sync <= key_meta;
			key_prev <= key_sync;
		end
	end

	assign up_press = key_sync[0] & ~key_prev[0];
	assign down_press = key_sync[1] & ~key_prev[1];
	assign sel_press = key_sync[2] & ~key_prev[2];
	assign ent_press = key_sync[3] & ~key_prev[3];

	// Setting sequence
	always_comb begin
		state_next = state_reg;
		if (sel_press) begin
			state_next = (state_reg == tarc_pkg::TARC_MENU_NORMAL) ? tarc_pkg::TARC_MENU_PICK
				: tarc_pkg::TARC_MENU_NORMAL;
		end else if (ent_press) begin
			case (state_reg)
				tarc_pkg::TARC_MENU_PICK: begin
					if (edit_reg == `TARC_PICK_INPUT) begin
						state_next = tarc_pkg::TARC_MENU_CURVE;
					end else if (edit_reg == `TARC_PICK_ALARM) begin
						state_next = tarc_pkg::TARC_MENU_ALARM_MENU_ENTRY;
					end else begin
						state_next = tarc_pkg::TARC_MENU_RELAY_ONE_SETTING;
					end
				end
				tarc_pkg::TARC_MENU_CURVE: state_next = tarc_pkg::TARC_MENU_UNITS;
				tarc_pkg::TARC_MENU_ALARM_MENU_ENTRY: begin
					state_next = edit_reg[0] ? tarc_pkg::TARC_MENU_HIGH_SETPOINT
						: tarc_pkg::TARC_MENU_NORMAL;
				end
				tarc_pkg::TARC_MENU_HIGH_SETPOINT: state_next = tarc_pkg::TARC_MENU_LOW_SETPOINT;
				tarc_pkg::TARC_MENU_LOW_SETPOINT: state_next = tarc_pkg::TARC_MENU_DEADBAND;
				tarc_pkg::TARC_MENU_DEADBAND: state_next = tarc_pkg::TARC_MENU_LATCH_SETTING;
				tarc_pkg::TARC_MENU_RELAY_ONE_SETTING: begin
					state_next = tarc_pkg::TARC_MENU_RELAY_TWO_SETTING;
				end
				default: state_next = tarc_pkg::TARC_MENU_NORMAL;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			state_reg <= tarc_pkg::TARC_MENU_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// Value shown on entering a setting, and its upper limit
	always_comb begin
		case (state_next)
			tarc_pkg::TARC_MENU_CURVE: load_val = {11'h000, curve_reg};
			tarc_pkg::TARC_MENU_UNITS: load_val = {14'h0000, units_reg};
			tarc_pkg::TARC_MENU_ALARM_MENU_ENTRY: load_val = {15'h0000, alarm_en_reg};
			tarc_pkg::TARC_MENU_HIGH_SETPOINT: load_val = {2'h0, hi_reg};
			tarc_pkg::TARC_MENU_LOW_SETPOINT: load_val = {2'h0, lo_reg};
			tarc_pkg::TARC_MENU_DEADBAND: load_val = {6'h00, db_reg};
			tarc_pkg::TARC_MENU_LATCH_SETTING: load_val = {15'h0000, latch_reg};
			tarc_pkg::TARC_MENU_RELAY_ONE_SETTING: load_val = {14'h0000, r1_reg};
			tarc_pkg::TARC_MENU_RELAY_TWO_SETTING: load_val = {14'h0000, r2_reg};
			tarc_pkg::TARC_MENU_PICK: load_val = pick_reg;
			default: load_val = 16'h0000;
		endcase
	end

	always_comb begin
		case (state_reg)
			tarc_pkg::TARC_MENU_PICK: edit_max = `TARC_PICK_MAX;
			tarc_pkg::TARC_MENU_ALARM_MENU_ENTRY: edit_max = `TARC_FLAG_MAX;
			tarc_pkg::TARC_MENU_LATCH_SETTING: edit_max = `TARC_FLAG_MAX;
			tarc_pkg::TARC_MENU_HIGH_SETPOINT: edit_max = `TARC_SETPT_MAX;
			tarc_pkg::TARC_MENU_LOW_SETPOINT: edit_max = `TARC_SETPT_MAX;
			tarc_pkg::TARC_MENU_DEADBAND: edit_max = `TARC_DBAND_MAX;
			tarc_pkg::TARC_MENU_RELAY_ONE_SETTING: edit_max = `TARC_RELAY_MAX;
			tarc_pkg::TARC_MENU_RELAY_TWO_SETTING: edit_max = `TARC_RELAY_MAX;
			default: edit_max = `TARC_UNITS_MAX;
		endcase
	end

	always_comb begin
		edit_next = edit_reg;
		if (state_next != state_reg) begin
			edit_next = load_val;
		end else if (state_reg == tarc_pkg::TARC_MENU_CURVE && (up_press || down_press)) begin
			edit_next = {11'h000, next_curve(edit_reg[4:0], up_press, i_input_type,
				i_user_curve_fmt, i_user_curve_valid)};
		end else if (state_reg == tarc_pkg::TARC_MENU_UNITS && (up_press || down_press)) begin
			if (curve_reg == `TARC_CURVE_NONE) begin
				edit_next = {14'h0000, tarc_pkg::TARC_UNITS_SENSOR};
			end else begin
				edit_next = {14'h0000, up_press ? edit_reg[1:0] + 2'h1
					: edit_reg[1:0] - 2'h1};
			end
		end else if (up_press && edit_reg < edit_max) begin
			edit_next = edit_reg + 16'h0001;
		end else if (down_press && edit_reg != 16'h0000) begin
			edit_next = edit_reg - 16'h0001;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			edit_reg <= 16'h0000;
		end else if (state_reg != tarc_pkg::TARC_MENU_NORMAL
				|| state_next != tarc_pkg::TARC_MENU_NORMAL) begin
			edit_reg <= edit_next;
		end
	end

	// Stored settings, each taken on its enter press
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			pick_reg <= `TARC_PICK_INPUT;
			curve_reg <= `TARC_RST_CURVE;
			alarm_en_reg <= 1'b0;
			hi_reg <= `TARC_RST_SETPT;
			lo_reg <= `TARC_RST_SETPT;
			db_reg <= `TARC_RST_DBAND;
			latch_reg <= 1'b0;
			r1_reg <= tarc_pkg::tarc_relay_e'(`TARC_RST_RELAY);
			r2_reg <= tarc_pkg::tarc_relay_e'(`TARC_RST_RELAY);
		end else if (ent_press && !sel_press) begin
			case (state_reg)
				tarc_pkg::TARC_MENU_PICK: pick_reg <= edit_reg;
				tarc_pkg::TARC_MENU_CURVE: curve_reg <= edit_reg[4:0];
				tarc_pkg::TARC_MENU_ALARM_MENU_ENTRY: alarm_en_reg <= edit_reg[0];
				tarc_pkg::TARC_MENU_HIGH_SETPOINT: hi_reg <= edit_reg[13:0];
				tarc_pkg::TARC_MENU_LOW_SETPOINT: lo_reg <= edit_reg[13:0];
				tarc_pkg::TARC_MENU_DEADBAND: db_reg <= edit_reg[9:0];
				tarc_pkg::TARC_MENU_LATCH_SETTING: latch_reg <= edit_reg[0];
				tarc_pkg::TARC_MENU_RELAY_ONE_SETTING: r1_reg <= tarc_pkg::tarc_relay_e'(edit_reg[1:0]);
				tarc_pkg::TARC_MENU_RELAY_TWO_SETTING: r2_reg <= tarc_pkg::tarc_relay_e'(edit_reg[1:0]);
				default: pick_reg <= pick_reg;
			endcase
		end
	end

	// Units fall back to sensor units whenever no curve is attached
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			units_reg <= tarc_pkg::tarc_units_e'(`TARC_RST_UNITS);
		end else if (curve_reg == `TARC_CURVE_NONE) begin
			units_reg <= tarc_pkg::TARC_UNITS_SENSOR;
		end else if (ent_press && !sel_press && state_reg == tarc_pkg::TARC_MENU_UNITS) begin
			units_reg <= tarc_pkg::tarc_units_e'(edit_reg[1:0]);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_unit_lamp <= 4'h1;
			o_curve <= `TARC_RST_CURVE;
		end else begin
			o_unit_lamp <= 4'h1 << units_reg;
			o_curve <= curve_reg;
		end
	end

	// Alarm conditions, all in tenths of a kelvin
	assign alarm_on = alarm_en_reg && curve_reg != `TARC_CURVE_NONE;
	assign hi_trip = i_reading_k > {2'h0, hi_reg} || i_above_curve;
	assign lo_trip = i_reading_k < {2'h0, lo_reg} || i_below_curve;
	assign hi_release = {1'b0, i_reading_k} + {7'h00, db_reg} <= {3'h0, hi_reg};
	assign lo_release = {1'b0, i_reading_k} >= {3'h0, lo_reg} + {7'h00, db_reg};

	tarc_alarm_flag u_high_flag (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_enable(alarm_on),
		.i_trip(hi_trip),
		.i_release(hi_release),
		.i_latch_en(latch_reg),
		.i_clear(sel_press),
		.o_flag(o_alarm_hi)
	);

	tarc_alarm_flag u_low_flag (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_enable(alarm_on),
		.i_trip(lo_trip),
		.i_release(lo_release),
		.i_latch_en(latch_reg),
		.i_clear(sel_press),
		.o_flag(o_alarm_lo)
	);

	// Relays: 1 with the low alarm, 2 with the high alarm
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_relay1 <= 1'b0;
			o_relay2 <= 1'b0;
		end else begin
			o_relay1 <= (r1_reg == tarc_pkg::TARC_RELAY_ON)
				|| (r1_reg == tarc_pkg::TARC_RELAY_FOLLOW && o_alarm_lo);
			o_relay2 <= (r2_reg == tarc_pkg::TARC_RELAY_ON)
				|| (r2_reg == tarc_pkg::TARC_RELAY_FOLLOW && o_alarm_hi);
		end
	end

	// Alternation rate divider
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || alt_tick) begin
			alt_cnt_reg <= 25'h0000000;
		end else begin
			alt_cnt_reg <= alt_cnt_reg + 25'h0000001;
		end
	end

	assign alt_tick = alt_cnt_reg == 25'(P_ALT_CYCLES - 1);

	always_comb begin
		show_next = o_disp.show;
		if (state_reg != tarc_pkg::TARC_MENU_NORMAL) begin
			show_next = tarc_pkg::TARC_SHOW_MENU;
		end else if (!o_alarm_hi && !o_alarm_lo) begin
			show_next = tarc_pkg::TARC_SHOW_READING;
		end else if (alt_tick) begin
			case (o_disp.show)
				tarc_pkg::TARC_SHOW_READING: begin
					show_next = o_alarm_hi ? tarc_pkg::TARC_SHOW_HIGH_ALARM_MESSAGE
						: tarc_pkg::TARC_SHOW_LOW_ALARM_MESSAGE;
				end
				tarc_pkg::TARC_SHOW_HIGH_ALARM_MESSAGE: begin
					show_next = o_alarm_lo ? tarc_pkg::TARC_SHOW_LOW_ALARM_MESSAGE
						: tarc_pkg::TARC_SHOW_READING;
				end
				default: show_next = tarc_pkg::TARC_SHOW_READING;
			endcase
		end else if ((o_disp.show == tarc_pkg::TARC_SHOW_HIGH_ALARM_MESSAGE && !o_alarm_hi)
				|| (o_disp.show == tarc_pkg::TARC_SHOW_LOW_ALARM_MESSAGE && !o_alarm_lo)
				|| o_disp.show == tarc_pkg::TARC_SHOW_MENU) begin
			show_next = tarc_pkg::TARC_SHOW_READING;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_disp <= '{tarc_pkg::TARC_SHOW_READING, tarc_pkg::TARC_MENU_NORMAL, 16'h0000};
		end else begin
			o_disp.show <= show_next;
			o_disp.item <= state_reg;
			if (state_reg != tarc_pkg::TARC_MENU_NORMAL) begin
				o_disp.value <= edit_reg;
			end else if (units_reg == tarc_pkg::TARC_UNITS_SENSOR) begin
				o_disp.value <= i_reading_raw;
			end else begin
				o_disp.value <= i_reading_k;
			end
		end
	end

	a_no_curve_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		curve_reg == `TARC_CURVE_NONE |=> !o_alarm_hi && !o_alarm_lo)
		else $error("alarm active without a curve");

	a_high_trip_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		alarm_on && (i_reading_k > {2'h0, hi_reg} || i_above_curve) |=> o_alarm_hi)
		else $error("high alarm missed");

	a_low_trip_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		alarm_on && (i_reading_k < {2'h0, lo_reg} || i_below_curve) |=> o_alarm_lo)
		else $error("low alarm missed");

	a_relay_one_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		r1_reg == tarc_pkg::TARC_RELAY_FOLLOW |=> o_relay1 == $past(o_alarm_lo))
		else $error("relay 1 not following low alarm");

	a_relay_two_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		r2_reg == tarc_pkg::TARC_RELAY_FOLLOW |=> o_relay2 == $past(o_alarm_hi))
		else $error("relay 2 not following high alarm");

	a_relay_forced: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		r1_reg != tarc_pkg::TARC_RELAY_FOLLOW |=> o_relay1 == ($past(r1_reg) == tarc_pkg::TARC_RELAY_ON))
		else $error("relay 1 ignores forced mode");

	a_units_need_curve: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		curve_reg == `TARC_CURVE_NONE |=> units_reg == tarc_pkg::TARC_UNITS_SENSOR)
		else $error("temperature units without a curve");

	a_setpoint_range: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		{2'h0, hi_reg} <= `TARC_SETPT_MAX && {2'h0, lo_reg} <= `TARC_SETPT_MAX)
		else $error("setpoint out of range");

	a_deadband_range: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		{6'h00, db_reg} <= `TARC_DBAND_MAX)
		else $error("deadband out of range");

	a_enable_skip: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_reg == tarc_pkg::TARC_MENU_ALARM_MENU_ENTRY && ent_press && !sel_press
		&& edit_reg == 16'h0000 |=> state_reg == tarc_pkg::TARC_MENU_NORMAL)
		else $error("alarm settings not skipped when disabled");

endmodule : tarc_top

// ### testbench/tarc_panel.sv
// Front-panel key model for the alarm and relay block.
// Assumes keys are sampled on i_ref_clk and acted on 3 clocks after a rise.
module tarc_panel (
	input wire logic i_ref_clk,
	output logic o_up,
	output logic o_down,
	output logic o_select,
	output logic o_enter
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{o_up, o_down, o_select, o_enter} = 4'h0;
	end

	// Key k: 0 up, 1 down, 2 select, 3 enter; presses spaced well apart
	task automatic press(input int k);
		@(posedge i_ref_clk);
		{o_up, o_down, o_select, o_enter} <= 4'h8 >> k;
		@(posedge i_ref_clk);
		{o_up, o_down, o_select, o_enter} <= 4'h0;
		repeat (5) @(posedge i_ref_clk);
	endtask : press

	task automatic step(input int k, input int n);
		repeat (n) press(k);
	endtask : step
endmodule : tarc_panel

// ### testbench/testbench.sv
// Self-checking bench for the alarm and relay block.
// Assumes tarc_top with a short display alternation period; input type starts as a diode.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, above, below, up, dn, sel, ent, a_hi, a_lo, r1, r2;
	logic [15:0] rd, raw;
	logic [2:0] itype;
	logic [1:0] ufmt;
	logic uvalid;
	logic [4:0] curve;
	logic [3:0] lamp;
	tarc_pkg::tarc_disp_s disp;
	int bad_count, check_count, seed, n;
	int hi_sp = 20, lo_sp = 10, db = 2;
	int seq[8] = '{21, 20, 19, 18, 9, 10, 11, 12};
	bit e_hi, e_lo;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	tarc_panel u_pn (.i_ref_clk(clk), .o_up(up), .o_down(dn), .o_select(sel), .o_enter(ent));

	tarc_top #(.P_ALT_CYCLES(8)) u_dut (
		.i_ref_clk(clk), .i_rstn(rstn), .i_key_up(up), .i_key_down(dn),
		.i_key_select(sel), .i_key_enter(ent), .i_input_type(itype),
		.i_user_curve_fmt(ufmt), .i_user_curve_valid(uvalid), .i_reading_k(rd),
		.i_reading_raw(raw), .i_above_curve(above), .i_below_curve(below),
		.o_alarm_hi(a_hi), .o_alarm_lo(a_lo), .o_relay1(r1), .o_relay2(r2),
		.o_curve(curve), .o_unit_lamp(lamp), .o_disp(disp)
	);

	task automatic chk(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	function automatic bit nxt_hi(bit cur, int r, bit ab, bit lt);
		if (r > hi_sp || ab) return 1'b1;
		if (lt || r + db > hi_sp) return cur;
		return 1'b0;
	endfunction : nxt_hi

	function automatic bit nxt_lo(bit cur, int r, bit bl, bit lt);
		if (r < lo_sp || bl) return 1'b1;
		if (lt || r < lo_sp + db) return cur;
		return 1'b0;
	endfunction : nxt_lo

	// Drive one reading, then compare alarms and follow-mode relays
	task automatic apply(input int r, input bit ab, input bit bl, input bit lt);
		@(posedge clk);
		rd <= 16'(r);
		above <= ab;
		below <= bl;
		e_hi = nxt_hi(e_hi, r, ab, lt);
		e_lo = nxt_lo(e_lo, r, bl, lt);
		repeat (3) @(posedge clk);
		#1;
		chk(a_hi === e_hi, "high alarm");
		chk(a_lo === e_lo, "low alarm");
		chk(r1 === e_lo, "relay one");
		chk(r2 === e_hi, "relay two");
	endtask : apply

	// Wait a bounded time for the display to show s
	task automatic wait_show(input tarc_pkg::tarc_show_e s, input string m);
		n = 0;
		while (n < 40 && disp.show !== s) begin
			@(posedge clk);
			n++;
		end
		chk(disp.show === s, m);
		if (disp.show !== s) begin
			print_verdict();
		end
	endtask : wait_show

	initial begin
		rstn = 1'b0;
		rd = 16'h000f;
		above = 1'b0;
		below = 1'b0;
		seed = $urandom(96);
		raw = 16'($urandom);
		itype = 3'h0;
		ufmt = 2'h0;
		uvalid = 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		chk(curve === 5'h01, "reset curve");
		chk(lamp === 4'h1, "reset lamp");
		chk({a_hi, a_lo, r1, r2} === 4'h0, "reset outputs");
		$display("test reset done");
		// Alarm on, high 20, low 10, deadband 2, latch off
		u_pn.press(2);
		chk(disp.show === tarc_pkg::TARC_SHOW_MENU, "menu shown");
		u_pn.step(0, 1);
		u_pn.press(3);
		u_pn.step(0, 1);
		u_pn.press(3);
		u_pn.step(0, hi_sp);
		u_pn.press(3);
		u_pn.step(0, lo_sp);
		u_pn.press(3);
		u_pn.step(0, db);
		u_pn.press(3);
		u_pn.press(3);
		chk(disp.item === tarc_pkg::TARC_MENU_NORMAL, "back to normal");
		// Both relays follow their alarms
		u_pn.press(2);
		u_pn.step(0, 1);
		u_pn.press(3);
		u_pn.step(0, 2);
		u_pn.press(3);
		u_pn.step(0, 2);
		u_pn.press(3);
		foreach (seq[i]) apply(seq[i], 1'b0, 1'b0, 1'b0);
		repeat (150) apply(5 + $urandom_range(20), $urandom_range(15) == 0,
			$urandom_range(15) == 0, 1'b0);
		$display("test hysteresis done");
		// Latch on, skipping the other settings
		u_pn.press(2);
		u_pn.step(1, 1);
		u_pn.step(3, 5);
		u_pn.step(0, 1);
		u_pn.press(3);
		apply(25, 1'b0, 1'b0, 1'b1);
		apply(5, 1'b0, 1'b0, 1'b1);
		apply(15, 1'b0, 1'b0, 1'b1);
		wait_show(tarc_pkg::TARC_SHOW_HIGH_ALARM_MESSAGE, "high message");
		wait_show(tarc_pkg::TARC_SHOW_LOW_ALARM_MESSAGE, "low message");
		u_pn.press(2);
		u_pn.press(2);
		e_hi = 1'b0;
		e_lo = 1'b0;
		apply(15, 1'b0, 1'b0, 1'b1);
		$display("test latch done");
		// Alarm off ends the settings and silences the alarms
		u_pn.press(2);
		u_pn.press(3);
		u_pn.step(1, 1);
		u_pn.press(3);
		chk(disp.item === tarc_pkg::TARC_MENU_NORMAL, "alarm off exit");
		rd <= 16'h0019;
		repeat (4) @(posedge clk);
		#1;
		chk({a_hi, a_lo, r2} === 3'h0, "alarm off quiet");
		$display("test disable done");
		// Curve ring per input format, units need a curve
		u_pn.press(2);
		u_pn.step(1, 1);
		u_pn.press(3);
		u_pn.step(0, 3);
		chk(disp.value === 16'h0000, "diode ring");
		itype <= 3'h2;
		ufmt <= 2'h1;
		uvalid <= 1'b1;
		u_pn.step(0, 3);
		chk(disp.value === 16'h0015, "resistor ring");
		u_pn.press(3);
		u_pn.step(0, 2);
		u_pn.press(3);
		chk(curve === 5'h15 && lamp === 4'h4, "user curve in F");
		chk(disp.value === rd, "kelvin reading shown");
		u_pn.press(2);
		u_pn.press(3);
		u_pn.step(0, 1);
		u_pn.press(3);
		u_pn.step(0, 1);
		chk(disp.value === 16'h0003, "sensor units only");
		u_pn.press(3);
		chk(lamp === 4'h8 && disp.value === raw, "raw reading shown");
		// Alarm on without a curve stays quiet
		u_pn.press(2);
		u_pn.step(0, 1);
		u_pn.press(3);
		u_pn.step(0, 1);
		u_pn.press(3);
		u_pn.press(2);
		above <= 1'b1;
		below <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk({a_hi, a_lo, r1, r2} === 4'h0, "no curve no alarm");
		$display("test curves done");
		print_verdict();
	end
endmodule : testbench
